// ===== dsb_map.svh
// constants for the drive setting bank: register offsets, field limits, reset values
// assumes an includer that uses these as plain `define names
`ifndef DSB_MAP_SVH
`define DSB_MAP_SVH

// ****************************************************************
// register offsets (word index on the plain register port)
// ****************************************************************
`define DSB_OFS_OVLD_WARN     8'h00
`define DSB_OFS_STATION       8'h01
`define DSB_OFS_BIT_RATE      8'h02
`define DSB_OFS_SET_PROT      8'h03
`define DSB_OFS_POS_PROT      8'h04
`define DSB_OFS_DECEL_TIME    8'h05
`define DSB_OFS_BOOT_VIEW     8'h06
`define DSB_OFS_STOP_SEQ      8'h07
`define DSB_OFS_APPLY         8'h08
`define DSB_OFS_IRQ_STATUS    8'h09
`define DSB_OFS_IRQ_MASK      8'h0A
`define DSB_OFS_POS_DATA_BASE 8'h10
`define DSB_POS_DATA_COUNT    16

// ****************************************************************
// limits and reset values
// ****************************************************************
`define DSB_OVLD_MIN          7'h0A
`define DSB_OVLD_MAX          7'h64
`define DSB_OVLD_RST          7'h32
`define DSB_OVLD_FUNC_CODE    8'h1B
`define DSB_STATION_MIN       5'h01
`define DSB_STATION_MAX       5'h1F
`define DSB_STATION_RST       5'h01
`define DSB_RATE_RST          2'h0
`define DSB_DECEL_MAX         20'hF423F
`define DSB_DECEL_RST         20'h003E8
`define DSB_VIEW_RST          6'h00
`define DSB_VIEW_MAX          6'h2D
`define DSB_VIEW_GAP_LO       6'h1C
`define DSB_VIEW_GAP_HI       6'h27
`define DSB_DECEL_REF_RPM     12'h7D0
`define DSB_DECEL_LSB_CLKS    32'h000003E8

// ****************************************************************
// interrupt status bit positions
// ****************************************************************
`define DSB_IRQ_WARN_BIT      0
`define DSB_IRQ_REFUSE_BIT    1
`define DSB_IRQ_STOP_BIT      2

`endif

// ===== dsb_pkg.sv
// types shared by the drive setting bank
// assumes dsb_map.svh is compiled alongside
`default_nettype none
package dsb_pkg;
	typedef enum logic [1:0] {
		DSB_RATE_38400  = 2'h0,
		DSB_RATE_19200  = 2'h1,
		DSB_RATE_9600   = 2'h2,
		DSB_RATE_115200 = 2'h3
	} dsb_rate_code_t;

	typedef enum logic [1:0] {
		DSB_STOP_IDLE,
		DSB_STOP_RAMP,
		DSB_STOP_HALT
	} dsb_stop_state_t;
endpackage
`default_nettype wire

// ===== dsb_decel_ramp.sv
// emergency stop ramp: fixed slope set by the time to fall from the reference speed
// assumes speed in r/min and time in 0.1 ms units, one tick per clock (100 ns)
`default_nettype none
`include "dsb_map.svh"
module dsb_decel_ramp (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    start,
	input  wire logic [11:0]             start_speed,
	input  wire logic [19:0]             decel_time,
	output logic                         ramping,
	output logic [11:0]                  ramp_speed
);
	import dsb_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		dsb_stop_state_t st;
		logic [11:0]     speed;
		logic [31:0]     acc;
	} dsb_ramp_t;

	dsb_ramp_t   r_ff;
	dsb_ramp_t   nxt_r;
	logic [31:0] step_len;

	// accumulated r/min per speed step; the largest time times 1000 still fits 32 bits
	assign step_len = {12'h0, decel_time} * `DSB_DECEL_LSB_CLKS;

	// 0.1 ms is 1000 clocks; per clock the speed falls by ref / (time*1000),
	// done with an accumulator so the slope is exact for times of 0.2 ms and up, and independent of start
	always_comb begin
		nxt_r = r_ff;
		case (r_ff.st)
			DSB_STOP_IDLE: begin
				if (start) begin
					nxt_r.speed = start_speed;
					nxt_r.acc   = 32'h0;
					nxt_r.st    = (decel_time == 20'h0) ? DSB_STOP_HALT : DSB_STOP_RAMP;
				end
			end
			DSB_STOP_RAMP: begin
				nxt_r.acc = r_ff.acc + {20'h0, `DSB_DECEL_REF_RPM};
				if (nxt_r.acc >= step_len) begin
					// carry the remainder so the mean slope stays exact
					nxt_r.acc = nxt_r.acc - step_len;
					if (r_ff.speed <= 12'h001) begin
						nxt_r.speed = 12'h0;
						nxt_r.st    = DSB_STOP_HALT;
					end else begin
						nxt_r.speed = r_ff.speed - 12'h001;
					end
				end
			end
			DSB_STOP_HALT: begin
				nxt_r.speed = 12'h0;
				if (!start) begin
					nxt_r.st = DSB_STOP_IDLE;
				end
			end
			default: begin
				nxt_r.st = DSB_STOP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_ff <= '{st: DSB_STOP_IDLE, speed: 12'h0, acc: 32'h0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign ramping    = (r_ff.st == DSB_STOP_RAMP);
	assign ramp_speed = r_ff.speed;
endmodule
`default_nettype wire

// ===== dsb_bank.sv
// drive setting bank: settings register file, protection, stop ramp trigger
// assumes a same-clock register master and pin inputs needing synchronising
//
// Contract
// - overload warning threshold 10..100 percent, reset 50; warn when level reaches it; the code holds the warning off while overload_alarm is set.
// - overload warning is output function code 27, an early overload alarm hint.
// - station number 1..31, reset 1; answer only frames addressed to it.
// - bit rate code 0=38400, 1=19200, 2=9600, 3=115200; reset 0.
// - setting protect set refuses all setting writes except the protect flag.
// - position data protect set refuses position data edits; clear accepts them.
// - emergency decel time 0.0..99999.9 ms, reset 100.0 ms.
// - ramp on forced stop, overtravel, safe stop, each when its setting selects it.
// - decel time means 2000 r/min to zero, so slope is fixed.
// - at power-up keypad shows the item chosen by the boot view code.
// - power-cycle settings take effect only after a reset; others at once.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`default_nettype none
`include "dsb_map.svh"
module dsb_bank (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic [31:0]                  reg_rdata,
	input  wire logic [6:0]              overload_level,
	input  wire logic                    overload_alarm,
	input  wire logic [4:0]              frame_station,
	input  wire logic                    frame_valid,
	input  wire logic                    forced_stop_pin,
	input  wire logic                    overtravel_pin,
	input  wire logic                    safe_stop_one_pin,
	input  wire logic [11:0]             motor_speed,
	output logic                         overload_warn,
	output logic [7:0]                   overload_warn_func,
	output logic                         frame_accept,
	output logic [4:0]                   link_station_number,
	output dsb_pkg::dsb_rate_code_t      link_bit_rate_code,
	output logic [5:0]                   keypad_view,
	output logic                         decel_active,
	output logic [11:0]                  decel_speed,
	output logic                         irq
);
	import dsb_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [6:0]  overload_warn_level;
		logic [4:0]  station_act;
		logic [1:0]  rate_act;
		logic        setting_protect_flag;
		logic        position_data_protect_flag;
		logic [19:0] emergency_decel_time;
		logic [5:0]  boot_view_act;
		logic [1:0]  servo_off_stop_sequence;
		logic [1:0]  overtravel_stop_sequence;
		logic        safety_stop_enable;
		logic        applied;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic [31:0] rdata;
		logic        warn;
		logic        accept;
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic [2:0]  stop_prev;
	} dsb_state_t;

	dsb_state_t s_ff;
	dsb_state_t nxt_s;

	// pending power-cycle values sit outside the reset, so that a reset is the power
	// cycle that brings them into use; the initial values stand for the first power-up
	typedef struct packed {
		logic [4:0] station_new;
		logic [1:0] rate_new;
		logic [5:0] boot_view_new;
	} dsb_keep_t;

	dsb_keep_t  keep_ff = '{station_new: `DSB_STATION_RST, rate_new: `DSB_RATE_RST,
	                        boot_view_new: `DSB_VIEW_RST};
	dsb_keep_t  nxt_keep;
	logic [31:0] pos_data_ff [`DSB_POS_DATA_COUNT];

	logic        ramp_start;
	logic        ramping;
	logic [11:0] ramp_speed;

	function automatic logic in_range32(input logic [31:0] v, input logic [31:0] lo,
	                                    input logic [31:0] hi);
		in_range32 = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic view_ok(input logic [31:0] v);
		view_ok = (v <= {26'h0, `DSB_VIEW_MAX}) &&
		          !((v >= {26'h0, `DSB_VIEW_GAP_LO}) && (v <= {26'h0, `DSB_VIEW_GAP_HI}));
	endfunction

	logic pos_hit;
	assign pos_hit = (reg_addr >= `DSB_OFS_POS_DATA_BASE) &&
	                 (reg_addr < (`DSB_OFS_POS_DATA_BASE + 8'h10));

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic       refuse;
		logic       ok;
		logic [2:0] stop_req;
		logic [2:0] events;
		refuse   = 1'b0;
		ok       = 1'b0;
		stop_req = 3'h0;
		events   = 3'h0;
		nxt_s    = s_ff;
		nxt_keep = keep_ff;

		// latched power-cycle values move to active only once after reset
		if (!s_ff.applied) begin
			nxt_s.station_act   = keep_ff.station_new;
			nxt_s.rate_act      = keep_ff.rate_new;
			nxt_s.boot_view_act = keep_ff.boot_view_new;
			nxt_s.applied       = 1'b1;
		end

		if (reg_write) begin
			ok = 1'b1;
			if (s_ff.setting_protect_flag && (reg_addr != `DSB_OFS_SET_PROT) &&
			    (reg_addr <= `DSB_OFS_STOP_SEQ)) begin
				ok = 1'b0;
			end
			case (reg_addr)
				`DSB_OFS_OVLD_WARN: begin
					if (ok && in_range32(reg_wdata, {25'h0, `DSB_OVLD_MIN},
					                     {25'h0, `DSB_OVLD_MAX})) begin
						nxt_s.overload_warn_level = reg_wdata[6:0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_STATION: begin
					if (ok && in_range32(reg_wdata, {27'h0, `DSB_STATION_MIN},
					                     {27'h0, `DSB_STATION_MAX})) begin
						nxt_keep.station_new = reg_wdata[4:0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_BIT_RATE: begin
					if (ok && (reg_wdata[31:2] == 30'h0)) begin
						nxt_keep.rate_new = reg_wdata[1:0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_SET_PROT: begin
					if (reg_wdata[31:1] == 31'h0) begin
						nxt_s.setting_protect_flag = reg_wdata[0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_POS_PROT: begin
					if (ok && (reg_wdata[31:1] == 31'h0)) begin
						nxt_s.position_data_protect_flag = reg_wdata[0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_DECEL_TIME: begin
					if (ok && in_range32(reg_wdata, 32'h0, {12'h0, `DSB_DECEL_MAX})) begin
						nxt_s.emergency_decel_time = reg_wdata[19:0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_BOOT_VIEW: begin
					if (ok && view_ok(reg_wdata)) begin
						nxt_keep.boot_view_new = reg_wdata[5:0];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_STOP_SEQ: begin
					if (ok && (reg_wdata[31:5] == 27'h0)) begin
						nxt_s.servo_off_stop_sequence  = reg_wdata[1:0];
						nxt_s.overtravel_stop_sequence = reg_wdata[3:2];
						nxt_s.safety_stop_enable       = reg_wdata[4];
					end else begin
						refuse = 1'b1;
					end
				end
				`DSB_OFS_IRQ_MASK: begin
					nxt_s.irq_mask = reg_wdata[2:0];
				end
				default: begin
					if (pos_hit && s_ff.position_data_protect_flag) begin
						refuse = 1'b1;
					end
				end
			endcase
		end

		// stop requests, each gated by its own sequence setting
		stop_req[0] = s_ff.sync2[0] && (s_ff.servo_off_stop_sequence == 2'h1);
		stop_req[1] = s_ff.sync2[1] && (s_ff.overtravel_stop_sequence == 2'h1);
		stop_req[2] = s_ff.sync2[2] && s_ff.safety_stop_enable;
		nxt_s.stop_prev = stop_req;
		nxt_s.sync1 = {safe_stop_one_pin, overtravel_pin, forced_stop_pin};
		nxt_s.sync2 = s_ff.sync1;

		nxt_s.warn = (overload_level >= s_ff.overload_warn_level) && !overload_alarm;
		nxt_s.accept = frame_valid && (frame_station == s_ff.station_act);

		events[`DSB_IRQ_WARN_BIT]   = nxt_s.warn && !s_ff.warn;
		events[`DSB_IRQ_REFUSE_BIT] = refuse;
		events[`DSB_IRQ_STOP_BIT]   = |(stop_req & ~s_ff.stop_prev);

		nxt_s.rdata = 32'h0;
		if (reg_read) begin
			case (reg_addr)
				`DSB_OFS_OVLD_WARN:  nxt_s.rdata = {25'h0, s_ff.overload_warn_level};
				`DSB_OFS_STATION:    nxt_s.rdata = {27'h0, keep_ff.station_new};
				`DSB_OFS_BIT_RATE:   nxt_s.rdata = {30'h0, keep_ff.rate_new};
				`DSB_OFS_SET_PROT:   nxt_s.rdata = {31'h0, s_ff.setting_protect_flag};
				`DSB_OFS_POS_PROT:   nxt_s.rdata = {31'h0, s_ff.position_data_protect_flag};
				`DSB_OFS_DECEL_TIME: nxt_s.rdata = {12'h0, s_ff.emergency_decel_time};
				`DSB_OFS_BOOT_VIEW:  nxt_s.rdata = {26'h0, keep_ff.boot_view_new};
				`DSB_OFS_STOP_SEQ:   nxt_s.rdata = {27'h0, s_ff.safety_stop_enable,
				                                    s_ff.overtravel_stop_sequence,
				                                    s_ff.servo_off_stop_sequence};
				`DSB_OFS_APPLY:      nxt_s.rdata = {15'h0, ramping, 3'h0, s_ff.station_act,
				                                    s_ff.rate_act, s_ff.boot_view_act};
				`DSB_OFS_IRQ_STATUS: nxt_s.rdata = {29'h0, s_ff.irq_status};
				`DSB_OFS_IRQ_MASK:   nxt_s.rdata = {29'h0, s_ff.irq_mask};
				default: begin
					if (pos_hit) begin
						nxt_s.rdata = pos_data_ff[reg_addr[3:0]];
					end
				end
			endcase
		end

		// read clears, but an event in the same cycle wins
		if (reg_read && (reg_addr == `DSB_OFS_IRQ_STATUS)) begin
			nxt_s.irq_status = events;
		end else begin
			nxt_s.irq_status = s_ff.irq_status | events;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '{overload_warn_level: `DSB_OVLD_RST, station_act: `DSB_STATION_RST,
			          rate_act: `DSB_RATE_RST, boot_view_act: `DSB_VIEW_RST,
			          emergency_decel_time: `DSB_DECEL_RST, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// no reset here: the written values must outlive the reset they wait for
	always_ff @(posedge clk) begin
		keep_ff <= nxt_keep;
	end

	// position data has no reset; contents are software owned
	always_ff @(posedge clk) begin
		if (reg_write && pos_hit && !s_ff.position_data_protect_flag) begin
			pos_data_ff[reg_addr[3:0]] <= reg_wdata;
		end
	end

	// ****************************************************************
	// stop ramp
	// ****************************************************************
	assign ramp_start = |s_ff.stop_prev;

	dsb_decel_ramp u_ramp (
		.clk         (clk),
		.reset_n     (reset_n),
		.start       (ramp_start),
		.start_speed (motor_speed),
		.decel_time  (s_ff.emergency_decel_time),
		.ramping     (ramping),
		.ramp_speed  (ramp_speed)
	);

	assign reg_rdata           = s_ff.rdata;
	assign overload_warn       = s_ff.warn;
	assign overload_warn_func  = `DSB_OVLD_FUNC_CODE;
	assign frame_accept        = s_ff.accept;
	assign link_station_number = s_ff.station_act;
	assign link_bit_rate_code  = dsb_rate_code_t'(s_ff.rate_act);
	assign keypad_view         = s_ff.boot_view_act;
	assign decel_active        = ramping;
	assign decel_speed         = ramp_speed;
	assign irq                 = |(s_ff.irq_status & s_ff.irq_mask);
endmodule
`default_nettype wire

// ===== dsb_bank_monitor.sv
// port assertions for the drive setting bank
// assumes it is bound into dsb_bank, one clock domain
`default_nettype none
module dsb_bank_monitor (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [6:0]  overload_level,
	input wire logic        overload_alarm,
	input wire logic [4:0]  frame_station,
	input wire logic        frame_valid,
	input wire logic        forced_stop_pin,
	input wire logic        overtravel_pin,
	input wire logic        safe_stop_one_pin,
	input wire logic        overload_warn,
	input wire logic [7:0]  overload_warn_func,
	input wire logic        frame_accept,
	input wire logic [4:0]  link_station_number,
	input wire logic [5:0]  keypad_view,
	input wire logic        decel_active,
	input wire logic [11:0] decel_speed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] up_ff;
	logic [1:0] nxt_up;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ****************************************
	// active copies may move only just after reset
	// ****************************************
	assign nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			up_ff <= 2'h0;
		end else begin
			up_ff <= nxt_up;
		end
	end
	sequence ramp_run;
		decel_active ##1 decel_active;
	endsequence
	sequence frame_hit;
		frame_valid && frame_station == link_station_number;
	endsequence
	chk_func_code: assert property (overload_warn_func == 8'h1B)
		else $error("warn function code wrong");
	chk_warn_floor: assert property (overload_level < 7'h0A |=> !overload_warn)
		else $error("warn below any threshold");
	chk_warn_full: assert property (overload_level == 7'h64 && !overload_alarm |=> overload_warn)
		else $error("warn missing at full level");
	chk_warn_alarm: assert property (overload_alarm |=> !overload_warn)
		else $error("warn during alarm");
	chk_frame_hit: assert property (frame_hit |=> frame_accept)
		else $error("own frame not accepted");
	chk_frame_cause: assert property (frame_accept |->
		$past(frame_valid) && $past(frame_station) == link_station_number)
		else $error("frame accepted without match");
	chk_station_range: assert property (link_station_number != 5'h00)
		else $error("station zero active");
	chk_active_hold: assert property (up_ff == 2'h3 |->
		$stable(link_station_number) && $stable(keypad_view))
		else $error("active setting moved without reset");
	chk_ramp_cause: assert property ($rose(decel_active) |->
		forced_stop_pin || overtravel_pin || safe_stop_one_pin)
		else $error("ramp without stop request");
	chk_ramp_fall: assert property (ramp_run |-> decel_speed <= $past(decel_speed))
		else $error("ramp speed rose");
	chk_ramp_end: assert property ($fell(decel_active) |-> decel_speed == 12'h000)
		else $error("ramp ended above zero");
endmodule
bind dsb_bank dsb_bank_monitor u_dsb_bank_monitor (.clk, .reset_n, .overload_level,
	.overload_alarm, .frame_station, .frame_valid, .forced_stop_pin, .overtravel_pin,
	.safe_stop_one_pin, .overload_warn, .overload_warn_func, .frame_accept,
	.link_station_number, .keypad_view, .decel_active, .decel_speed);
`default_nettype wire

// ===== dsb_host_model.sv
// host side of the register port: write and read cycles
// assumes read data stand only in the cycle after the strobe
`default_nettype none
module dsb_host_model (
	input  wire logic        clk,
	input  wire logic [31:0] reg_rdata,
	output var  logic [7:0]  reg_addr,
	output var  logic [31:0] reg_wdata,
	output var  logic        reg_write,
	output var  logic        reg_read
);
	timeunit 1ns;
	timeprecision 1ns;
	int gap = 0;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	// released lines show junk, not the last value
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		repeat (gap + 1) @(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_wdata <= ~v;
		reg_addr <= ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		repeat (gap + 1) @(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		#1 v = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== dsb_bank_test.sv
// bench for the drive setting bank against a register model
// assumes dsb_bank, dsb_host_model and the bound monitor
`default_nettype none
module dsb_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_write;
	logic        reg_read;
	logic [6:0]  overload_level = 7'h00;
	logic        overload_alarm = 1'b0;
	logic [4:0]  frame_station = 5'h00;
	logic        frame_valid = 1'b0;
	logic [2:0]  pin = 3'h0;
	logic [11:0] motor_speed = 12'h000;
	logic        overload_warn;
	logic [7:0]  overload_warn_func;
	logic        frame_accept;
	logic [4:0]  link_station_number;
	logic [1:0]  link_bit_rate_code;
	logic [5:0]  keypad_view;
	logic        decel_active;
	logic [11:0] decel_speed;
	logic        irq;
	logic [31:0] d;
	logic [31:0] lf = 32'h36812B6C;
	int          n_fail = 0;
	int          n_compared = 0;
	int          mdl [32];
	int          t;
	int          e;
	int          tv [$] = '{0, 9, 0, 10, 0, 100, 0, 101, 1, 0, 1, 32, 1, 31, 5, 0, 5, 1000000,
		5, 999999, 6, 28, 6, 46, 6, 45, 6, 40, 3, 2, 4, 2};
	dsb_bank u_dsb_bank (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .overload_level, .overload_alarm, .frame_station, .frame_valid,
		.forced_stop_pin(pin[0]), .overtravel_pin(pin[1]), .safe_stop_one_pin(pin[2]),
		.motor_speed, .overload_warn, .overload_warn_func, .frame_accept,
		.link_station_number, .link_bit_rate_code, .keypad_view, .decel_active,
		.decel_speed, .irq);
	dsb_host_model u_dsb_host_model (.clk, .reg_rdata, .reg_addr, .reg_wdata,
		.reg_write, .reg_read);
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// ****************************************
	// model: protect gates 0x00-0x07 but not itself
	// ****************************************
	function automatic bit ok(input int a, input int v);
		if (a >= 16) return mdl[4] == 0;
		if (a != 3 && mdl[3] != 0) return 0;
		case (a)
			0: return v >= 10 && v <= 100;
			1: return v >= 1 && v <= 31;
			2: return v <= 3;
			5: return v <= 999999;
			6: return v <= 27 || (v >= 40 && v <= 45);
			default: return v <= 1 || a == 7;
		endcase
	endfunction
	task automatic wr(input int a, input int v);
		u_dsb_host_model.wr(a[7:0], v);
		if (a == 10 || ok(a, v)) begin
			mdl[a] = v;
		end else begin
			mdl[9] |= 2;
		end
	endtask
	task automatic rd(input int a);
		u_dsb_host_model.rd(a[7:0], d);
		if (mdl[a] >= 0) begin
			chk($sformatf("reg %0h", a), mdl[a], d);
		end
		if (a == 9) begin
			mdl[9] = 0;
		end
	endtask
	task automatic do_reset;
		@(posedge clk) reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		mdl[8] = (mdl[1] << 8) | (mdl[2] << 6) | mdl[6];
		mdl[9] = 0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic frames;
		for (int s = 0; s < 32; s++) begin
			@(posedge clk) begin
				frame_station <= s[4:0];
				frame_valid <= 1'b1;
			end
			@(posedge clk) frame_valid <= 1'b0;
			#1 chk("accept", s == ((mdl[8] >> 8) & 31), frame_accept);
		end
	endtask
	// only the running time is measured; sync delay is excluded
	task automatic ramp(input int j, input int spd);
		t = 0;
		@(posedge clk) begin
			motor_speed <= spd[11:0];
			pin[j] <= 1'b1;
		end
		for (int w = 0; w < 10 && decel_active !== 1'b1; w++) @(posedge clk);
		if (decel_active === 1'b1) chk("ramp speed", spd, decel_speed);
		while (decel_active === 1'b1) begin
			@(posedge clk);
			t++;
			if (t > 6000) begin
				n_fail++;
				results();
			end
		end
		@(posedge clk) pin[j] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		mdl = '{default: 0};
		for (int i = 16; i < 32; i++) mdl[i] = -1;
		mdl[0] = 50;
		mdl[1] = 1;
		mdl[5] = 1000;
		mdl[7] = -1;
		do_reset();
		for (int a = 0; a < 12; a++) rd(a);
		u_dsb_host_model.wr(8'h0B, 32'h0000FFFF);
		rd(11);
		chk("function code", 27, overload_warn_func);
		$display("test reset values done");
		for (int i = 0; i < tv.size(); i += 2) begin
			wr(tv[i], tv[i + 1]);
			rd(tv[i]);
		end
		for (int r = 0; r < 4; r++) begin
			wr(2, r);
			rd(2);
		end
		rd(9);
		rd(8);
		for (int i = 16; i < 32; i++) begin
			lf = lfsr(lf);
			wr(i, lf[30:0]);
			wr(0, lf[6:0]);
			rd(i);
			rd(0);
		end
		$display("test ranges done");
		u_dsb_host_model.gap = 2;
		wr(4, 1);
		wr(16, 32'h55);
		rd(16);
		wr(3, 1);
		wr(0, 60);
		wr(4, 0);
		rd(0);
		rd(4);
		wr(3, 0);
		rd(3);
		wr(16, 32'hAA);
		rd(16);
		wr(4, 0);
		wr(16, 32'hAA);
		rd(16);
		rd(9);
		u_dsb_host_model.gap = 0;
		$display("test protect done");
		for (int m = 1; m >= 0; m--) begin
			wr(10, m);
			wr(0, 60);
			rd(9);
			@(posedge clk) overload_level <= 7'h3B;
			settle();
			chk("warn", 0, overload_warn);
			@(posedge clk) overload_level <= 7'h3C;
			settle();
			mdl[9] |= 1;
			chk("warn", 1, overload_warn);
			chk("irq", m, irq);
			@(posedge clk) overload_alarm <= 1'b1;
			settle();
			chk("warn", 0, overload_warn);
			@(posedge clk) begin
				overload_alarm <= 1'b0;
				overload_level <= 7'h00;
			end
			rd(9);
			settle();
			chk("irq", 0, irq);
		end
		frames();
		$display("test warn and frames done");
		@(posedge clk) overload_level <= 7'h64;
		wr(5, 20);
		for (int k = 0; k < 3; k++) begin
			wr(7, 1 << (2 * k));
			for (int j = 0; j < 3; j++) begin
				ramp(j, 100 * k + 100);
				e = (100 * k + 100) * 20 * 1000 / 2000;
				chk("ramp started", j == k, t > 0);
				if (j == k) begin
					chk("ramp time", 1, t >= e - e / 50 - 4 && t <= e + e / 50 + 4);
				end
			end
		end
		$display("test stop ramp done");
		rd(8);
		do_reset();
		rd(8);
		chk("view", mdl[6], keypad_view);
		chk("rate", mdl[2], link_bit_rate_code);
		chk("station", (mdl[8] >> 8) & 31, link_station_number);
		frames();
		$display("test power cycle done");
		results();
	end
endmodule
`default_nettype wire
